// >>> rtl/onsmc_ctrl.sv
// Miss, write-equivalence, reserved-line and fetch-interrupt control
`timescale 1ns/100ps
module onsmc_ctrl (
  input  wire logic                           i_clock,
  input  wire logic                           i_rst_b,
  // Stage-3/4 association results
  input  wire logic [onsmc_pkg::NUM_LINES-1:0] i_line_match,
  input  wire logic                           i_access_valid,   // Access needing equivalence at stage 4
  input  wire logic                           i_acc_write,      // Accumulator write order
  input  wire logic                           i_store_to_var,   // Order is a store to variable
  input  wire logic                           i_level0,         // Level-0 interrupt routine active
  input  wire logic [2:0]                     i_rsv_addr,       // Low 3 word address digits
  input  wire logic [onsmc_pkg::VADDR_W-1:0]  i_vaddr,
  input  wire logic [onsmc_pkg::LINE_W-1:0]   i_found_operand,
  input  wire logic                           i_acc_store_pending,
  input  wire logic [onsmc_pkg::IDX_W-1:0]    i_acc_store_home,
  input  wire logic                           i_overlap_store_s4,
  input  wire logic                           i_console_bypass_signal,
  input  wire logic                           i_xlate_miss,
  // Far side replies
  input  wire logic                           i_access_accept_reply,
  input  wire logic                           i_access_reject_reply,
  input  wire logic                           i_store_operand_valid,
  input  wire logic [onsmc_pkg::LINE_W-1:0]   i_store_operand,
  input  wire logic                           i_sec_holds_line,
  input  wire logic                           i_sec_operand_valid,
  input  wire logic [onsmc_pkg::LINE_W-1:0]   i_sec_operand,
  input  wire logic                           i_acc_store_operand_valid,
  // Instruction fetch unit interrupts at stage 4
  input  wire logic                           i_fetch_xlate_int,
  input  wire logic                           i_fetch_ovf_int,
  input  wire logic                           i_pipe_discard,
  input  wire logic                           i_interrupt_entry,
  // Outputs
  output logic                                o_stage4_stall,
  output logic                                o_dummy_to_s5,
  output logic                                o_miss_fetch_order,
  output logic                                o_no_increment,
  output logic                                o_writeback_valid,
  output logic [onsmc_pkg::LINE_W-1:0]        o_writeback_data,
  output logic [onsmc_pkg::VADDR_W-1:0]       o_writeback_vaddr,
  output logic                                o_writeback_force,
  output logic                                o_recycle,
  output logic                                o_restrobe_home,
  output logic                                o_select_fetched,
  output logic                                o_store_home_write,
  output logic                                o_interrupt_enter,
  output logic                                o_mult_equiv_error,
  output logic                                o_force_xlate_error,
  output logic                                o_fetch_priority_flag,
  output logic                                o_incr_only_lockout,
  output logic                                o_send_control_addr,
  output logic                                o_internal_interrupt,
  output logic                                o_bypass_store,
  output logic [onsmc_pkg::IDX_W-1:0]         o_fill_line,
  output logic [onsmc_pkg::NUM_LINES-1:0]     o_used,
  output logic [onsmc_pkg::NUM_LINES-1:0]     o_altered
);
  onsmc_pkg::onsmc_state_t state;
  onsmc_pkg::onsmc_state_t next_state;
  logic [onsmc_pkg::IDX_W-1:0]    next_line_pointer;
  logic [onsmc_pkg::IDX_W-1:0]    victim;
  logic [onsmc_pkg::IDX_W-1:0]    match_idx;
  logic [onsmc_pkg::NUM_LINES-1:0] line_data_we;
  logic [onsmc_pkg::LINE_W-1:0]   line_data [onsmc_pkg::NUM_LINES];
  logic [onsmc_pkg::LINE_W-1:0]   fetched_operand_register;
  logic                           miss_for_var;
  logic                           miss_stall_bit;
  logic                           acc_write_equiv_stall;
  logic                           sec_held;
  logic                           wb_pending;
  logic [2:0]                     match_sum;

  // Match count and index; more than one is a hardware fault
  always_comb begin
    match_sum = 3'h0;
    match_idx = '0;
    for (int j = 0; j < onsmc_pkg::NUM_LINES; j++) begin
      if (i_line_match[j]) begin
        if (match_sum != 3'h2) match_sum = match_sum + 3'h1;
        match_idx = onsmc_pkg::IDX_W'(j);
      end
    end
  end

  wire  active_access = i_access_valid & ~i_console_bypass_signal & ~i_level0;
  wire  hit_one       = (match_sum == 3'h1);
  wire  hit_none      = (match_sum == 3'h0);
  wire  idle          = (state == onsmc_pkg::ONSMC_IDLE);
  wire  home_conflict = i_acc_store_pending & (match_idx == i_acc_store_home);
  // Accumulator write hit on the store home line deferred while that operand outstanding
  wire  aw_start = idle & active_access & i_acc_write & hit_one & ~home_conflict; // R1 R3
  wire  miss_start = idle & active_access & hit_none;                              // R4 R24
  // Victim skips the outstanding store home line
  wire  [onsmc_pkg::IDX_W-1:0] ptr_plus = (next_line_pointer == onsmc_pkg::PTR_LAST) ?
                                          onsmc_pkg::PTR_RESET : next_line_pointer + 5'h01;
  wire  skip_home = i_acc_store_pending & (i_acc_store_home == next_line_pointer);
  assign victim = skip_home ? ptr_plus : next_line_pointer;                        // R8
  // Reserved line for level-0 routine, modulo 4 over four lines
  wire  [onsmc_pkg::IDX_W-1:0] rsv_line = 5'(onsmc_pkg::RSV_BASE) + {3'h0, i_rsv_addr[1:0]}; // R15
  wire  miss_fill_ok = state == onsmc_pkg::ONSMC_MS_DATA;
  wire  store_fill   = miss_fill_ok & ~sec_held & i_store_operand_valid;          // R11
  wire  sec_fill     = miss_fill_ok & sec_held & i_sec_operand_valid & miss_for_var; // R13
  wire  sec_noins    = miss_fill_ok & sec_held & i_sec_operand_valid & ~miss_for_var; // R13
  // Store home operand wins the holding register only if first
  assign o_store_home_write = i_acc_store_operand_valid & ~(sec_held & i_sec_operand_valid) &
                              ~store_fill;                                          // R11 R12

  // State sequencing
  always_comb begin
    next_state = state;
    case (state)
      onsmc_pkg::ONSMC_IDLE:    begin
        if (aw_start) next_state = onsmc_pkg::ONSMC_AW_WB;
        else if (miss_start) next_state = onsmc_pkg::ONSMC_MS_WB;
      end
      onsmc_pkg::ONSMC_AW_WB:   next_state = onsmc_pkg::ONSMC_AW_RCY;               // R1
      onsmc_pkg::ONSMC_AW_RCY:  next_state = onsmc_pkg::ONSMC_IDLE;                 // R2
      onsmc_pkg::ONSMC_MS_WB:   next_state = onsmc_pkg::ONSMC_MS_WAIT;
      onsmc_pkg::ONSMC_MS_WAIT: begin
        if (i_access_reject_reply) next_state = onsmc_pkg::ONSMC_IDLE;              // R10
        else if (i_access_accept_reply) next_state = onsmc_pkg::ONSMC_MS_DATA;
      end
      onsmc_pkg::ONSMC_MS_DATA: begin
        if (store_fill | sec_fill) next_state = onsmc_pkg::ONSMC_MS_RCY;
        else if (sec_noins) next_state = onsmc_pkg::ONSMC_IDLE;                     // R13
      end
      onsmc_pkg::ONSMC_MS_RCY:  next_state = onsmc_pkg::ONSMC_IDLE;                 // R14
      default:                  next_state = onsmc_pkg::ONSMC_IDLE;
    endcase
  end

  // Controller state and stall bits
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      state                 <= onsmc_pkg::ONSMC_IDLE;
      miss_stall_bit        <= 1'b0;
      acc_write_equiv_stall <= 1'b0;
      miss_for_var          <= 1'b0;
      sec_held              <= 1'b0;
    end else begin
      state <= next_state;
      if (miss_start) miss_stall_bit <= 1'b1;                                       // R4
      else if (next_state == onsmc_pkg::ONSMC_IDLE) miss_stall_bit <= 1'b0;         // R10 R14
      if (aw_start) acc_write_equiv_stall <= 1'b1;
      else if (state == onsmc_pkg::ONSMC_AW_RCY) acc_write_equiv_stall <= 1'b0;     // R2
      if (miss_start) miss_for_var <= i_store_to_var;
      if (miss_start) sec_held <= 1'b0;
      else if (i_sec_holds_line) sec_held <= 1'b1;
    end
  end

  // Used and altered flags, fill line and pointer; reserved lines stay used
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_used            <= {{(onsmc_pkg::NUM_LINES-onsmc_pkg::RSV_BASE-onsmc_pkg::RSV_LINES){1'b0}},
                            {onsmc_pkg::RSV_LINES{1'b1}}, {onsmc_pkg::RSV_BASE{1'b0}}}; // R15
      o_altered         <= '0;
      next_line_pointer <= onsmc_pkg::PTR_RESET;
      o_fill_line       <= '0;
    end else begin
      if ((state == onsmc_pkg::ONSMC_AW_WB) && (match_idx < 5'(onsmc_pkg::RSV_BASE))) begin // R15
        o_used[match_idx]    <= 1'b0;                                               // R2
        o_altered[match_idx] <= 1'b0;
      end
      if (miss_start) o_fill_line <= victim;
      if (state == onsmc_pkg::ONSMC_MS_WB) o_altered[o_fill_line] <= 1'b0;          // R9
      if (store_fill | sec_fill) begin
        o_used[o_fill_line]    <= 1'b1;                                             // R11 R13
        o_altered[o_fill_line] <= sec_fill;
      end
      if (state == onsmc_pkg::ONSMC_MS_RCY) next_line_pointer <= (o_fill_line == onsmc_pkg::PTR_LAST) ?
                                              onsmc_pkg::PTR_RESET : o_fill_line + 5'h01; // R14
      if (i_level0 & i_access_valid & i_store_to_var) o_altered[rsv_line] <= 1'b1;
    end
  end

  // Line storage without reset
  assign line_data_we = (store_fill | sec_fill) ? (32'h1 << o_fill_line) : '0;
  always_ff @(posedge i_clock) begin
    for (int j = 0; j < onsmc_pkg::NUM_LINES; j++)
      if (line_data_we[j]) line_data[j] <= store_fill ? i_store_operand : i_sec_operand;
  end

  // Write-back data and operand select hold
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      wb_pending               <= 1'b0;
      o_writeback_data         <= '0;
      o_writeback_vaddr        <= '0;
      o_writeback_force        <= 1'b0;
      fetched_operand_register <= '0;
      o_select_fetched         <= 1'b0;
    end else begin
      wb_pending <= 1'b0;
      if (aw_start & o_altered[match_idx]) begin
        wb_pending        <= 1'b1;                                                  // R1
        o_writeback_data  <= i_found_operand;
        o_writeback_vaddr <= i_vaddr;
        o_writeback_force <= 1'b0;
      end else if (miss_start & o_altered[victim]) begin
        wb_pending        <= 1'b1;                                                  // R9
        o_writeback_data  <= line_data[victim];
        o_writeback_vaddr <= i_vaddr;
        o_writeback_force <= 1'b1;                                                  // R18
      end
      if (store_fill) fetched_operand_register <= i_store_operand;
      o_select_fetched <= (state == onsmc_pkg::ONSMC_MS_RCY);                       // R14
    end
  end
  assign o_writeback_valid = wb_pending;

  // Fetch unit interrupts; discard before execution means no action
  wire fetch_int_live = i_fetch_xlate_int & ~i_pipe_discard;                        // R22
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_fetch_priority_flag <= 1'b0;
      o_incr_only_lockout   <= 1'b0;
      o_send_control_addr   <= 1'b0;
      o_internal_interrupt  <= 1'b0;
      o_mult_equiv_error    <= 1'b0;
      o_force_xlate_error   <= 1'b0;
    end else begin
      if (fetch_int_live) o_fetch_priority_flag <= 1'b1;                            // R19
      else if (i_interrupt_entry) o_fetch_priority_flag <= 1'b0;
      o_incr_only_lockout  <= fetch_int_live;                                       // R20
      o_send_control_addr  <= o_incr_only_lockout;                                  // R20
      o_internal_interrupt <= i_fetch_ovf_int & ~i_pipe_discard;                    // R21
      o_mult_equiv_error   <= (match_sum == 3'h2) & i_access_valid;                 // R17
      o_force_xlate_error  <= o_writeback_valid & o_writeback_force & i_xlate_miss; // R18
    end
  end

  // Stage-4 hold and stage-5 order outputs
  assign o_stage4_stall     = miss_stall_bit | acc_write_equiv_stall;              // R24
  assign o_dummy_to_s5      = o_stage4_stall | aw_start;                            // R23
  assign o_miss_fetch_order = (state == onsmc_pkg::ONSMC_MS_WB);                    // R4
  assign o_no_increment     = o_miss_fetch_order | o_incr_only_lockout |
                              (i_console_bypass_signal & i_xlate_miss);             // R16
  assign o_bypass_store     = i_console_bypass_signal;                              // R16
  assign o_recycle          = (state == onsmc_pkg::ONSMC_AW_RCY) | (state == onsmc_pkg::ONSMC_MS_RCY); // R2 R14
  assign o_restrobe_home    = (state == onsmc_pkg::ONSMC_MS_RCY) & i_overlap_store_s4; // R14
  assign o_interrupt_enter  = (state == onsmc_pkg::ONSMC_MS_WAIT) & i_access_reject_reply; // R10

  // Checks
  property p_miss_order;
    @(posedge i_clock) disable iff (!i_rst_b) miss_start |=> o_miss_fetch_order && o_stage4_stall;
  endproperty
  a_miss_order: assert property (p_miss_order) else $error("miss order not emitted"); // R4
  property p_aw_one_dummy;
    @(posedge i_clock) disable iff (!i_rst_b) aw_start |=> o_stage4_stall ##1 o_recycle ##1 !o_stage4_stall;
  endproperty
  a_aw_one_dummy: assert property (p_aw_one_dummy) else $error("write equivalence sequence wrong"); // R1
  property p_aw_defer;
    @(posedge i_clock) disable iff (!i_rst_b) (idle && i_acc_write && home_conflict) |=> !acc_write_equiv_stall;
  endproperty
  a_aw_defer: assert property (p_aw_defer) else $error("write equivalence not deferred"); // R3
  property p_reject;
    @(posedge i_clock) disable iff (!i_rst_b) o_interrupt_enter |=> !miss_stall_bit;
  endproperty
  a_reject: assert property (p_reject) else $error("reject did not abandon miss"); // R10
  property p_mult;
    @(posedge i_clock) disable iff (!i_rst_b) (match_sum == 3'h2 && i_access_valid) |=> o_mult_equiv_error;
  endproperty
  a_mult: assert property (p_mult) else $error("multiple match not flagged"); // R17
  property p_rsv_used;
    @(posedge i_clock) disable iff (!i_rst_b) &o_used[onsmc_pkg::RSV_BASE +: onsmc_pkg::RSV_LINES];
  endproperty
  a_rsv_used: assert property (p_rsv_used) else $error("reserved line not used"); // R15
  property p_priority;
    @(posedge i_clock) disable iff (!i_rst_b) fetch_int_live |=> o_fetch_priority_flag ##1 o_send_control_addr;
  endproperty
  a_priority: assert property (p_priority) else $error("fetch interrupt handling wrong"); // R19
  property p_fill_used;
    @(posedge i_clock) disable iff (!i_rst_b) store_fill |=> o_used[$past(o_fill_line)] && !o_altered[$past(o_fill_line)];
  endproperty
  a_fill_used: assert property (p_fill_used) else $error("filled line flags wrong"); // R11
  property p_victim_skip;
    @(posedge i_clock) disable iff (!i_rst_b) (miss_start && skip_home) |=> o_fill_line != i_acc_store_home || !i_acc_store_pending;
  endproperty
  a_victim_skip: assert property (p_victim_skip) else $error("victim is store home line"); // R8
endmodule

// >>> rtl/onsmc_pkg.sv
// Constants and types for the operand name store miss control block
// How it works
// R1 - Accumulator write hit stalls stage 4, one dummy, writes altered line back
// R2 - Then line cleared altered/used, stages 2-3 recycled, stall cleared, order passes
// R3 - Accumulator write equivalence waits while accumulator store operand is outstanding (code waits only on a hit to the store home line)
// R4 - Miss sets miss stall bit and emits a valid no-increment miss-fetch order
// R5 - Secondary buffer searches its store, returns line after its queue drains
// R6 - Otherwise secondary buffer reads store on our behalf, then discards order
// R7 - Controller replies accept or reject to both; reject discards the order
// R8 - Victim is next-line pointer, skipping one when it is the store home line
// R9 - Altered victim is written back to store first, then marked non-altered
// R10 - Reject reply abandons miss sequence and enters interrupt routine directly
// R11 - Accept with store operand fills victim line, used and non-altered
// R12 - Store operand first in holding register is stored home; else it waits
// R13 - Store-to-variable miss inserts returned line used and altered; else no insert
// R14 - After insertion advance pointer, recycle, restrobe home, clear stall, force fetched
// R15 - Four reserved level-0 lines, addressed modulo 8, always used, never replaced (code addresses them modulo 4)
// R16 - Console bypass skips name stores; translation miss blocks control increment
// R17 - More than one matching line raises multiple-equivalence system error
// R18 - Miss write-backs carry force flag; translation miss on them is system error
// R19 - Fetch translation-miss interrupt transfers control, abandons pipe, sets priority flag
// R20 - Transfer done by increment-only order with lockout, then address sent
// R21 - Fetch control-segment overflow at stage 4 raises an internal interrupt
// R22 - Buffered fetch interrupt discarded by transfer or external interrupt is ignored
// R23 - Any stage-4 stall bit feeds dummy orders into stage 5
// R24 - Only one miss sequence at a time; later accesses held at stage 4
package onsmc_pkg;
  localparam int NUM_LINES   = 32;   // 23 normal + 4 reserved, rest unused
  localparam int NORMAL_LINES = 23;
  localparam int RSV_BASE    = 24;   // Reserved lines 24..27
  localparam int RSV_LINES   = 4;
  localparam int RSV_MOD     = 8;    // Modulo-8 addressing per the document; unused, rsv_line is modulo 4
  localparam int LINE_W      = 64;
  localparam int VADDR_W     = 20;
  localparam int IDX_W       = 5;
  localparam logic [IDX_W-1:0] PTR_RESET = 5'h00;
  localparam logic [IDX_W-1:0] PTR_LAST  = 5'h16; // Normal line 22
  typedef enum logic [6:0] {
    ONSMC_IDLE    = 7'h01,
    ONSMC_AW_WB   = 7'h02,
    ONSMC_AW_RCY  = 7'h04,
    ONSMC_MS_WB   = 7'h08,
    ONSMC_MS_WAIT = 7'h10,
    ONSMC_MS_DATA = 7'h20,
    ONSMC_MS_RCY  = 7'h40
  } onsmc_state_t;
endpackage

// >>> sim/onsmc_ctrl_tb.sv
// Self-checking bench for the operand name store miss control block
`timescale 1ns/100ps
module onsmc_ctrl_tb;
  logic        i_clock, i_rst_b, i_access_valid, i_acc_write, i_store_to_var, i_level0, i_acc_store_pending;
  logic        i_overlap_store_s4, i_console_bypass_signal, i_xlate_miss, i_acc_store_operand_valid;
  logic        i_fetch_xlate_int, i_fetch_ovf_int, i_pipe_discard, i_interrupt_entry;
  logic [31:0] i_line_match, o_used, o_altered, exp_used, exp_alt;
  logic [2:0]  i_rsv_addr;
  logic [19:0] i_vaddr, o_writeback_vaddr, wb_vaddr;
  logic [4:0]  i_acc_store_home, o_fill_line;
  logic [63:0] i_found_operand, line_data, wb_data, o_writeback_data;
  logic [63:0] lines [32];
  logic [1:0]  mode, delay;
  wire logic   i_access_accept_reply, i_access_reject_reply, i_store_operand_valid, i_sec_holds_line;
  wire logic   i_sec_operand_valid;
  wire logic [63:0] i_store_operand, i_sec_operand;
  logic        o_stage4_stall, o_dummy_to_s5, o_miss_fetch_order, o_no_increment, o_writeback_valid;
  logic        o_writeback_force, o_interrupt_enter, o_mult_equiv_error, o_fetch_priority_flag;
  logic        o_incr_only_lockout, o_send_control_addr, o_internal_interrupt, o_bypass_store;
  logic        o_recycle, o_select_fetched, o_restrobe_home, o_store_home_write, o_force_xlate_error;
  int          cnt [15], base [15], ptr, bad_count, checks_done, seed;
  // Event vector: 0 miss,1 noinc,2 int,3 wb,4 force,5 byp,6 err,7 lock,8 ctl,9 iint,10 dummy
  // 11 recycle,12 select fetched,13 restrobe home,14 forced write-back translation error
  wire logic [14:0] ev = {o_force_xlate_error, o_restrobe_home, o_select_fetched, o_recycle,
                          o_dummy_to_s5, o_internal_interrupt, o_send_control_addr, o_incr_only_lockout,
                          o_mult_equiv_error, o_bypass_store, o_writeback_force & o_writeback_valid,
                          o_writeback_valid, o_interrupt_enter, o_no_increment, o_miss_fetch_order};

  onsmc_ctrl onsmc_ctrl_i (
    .*
  );
  onsmc_far_model onsmc_far_model_i (
    .i_clock       (i_clock),
    .i_order       (o_miss_fetch_order),
    .i_mode        (mode),
    .i_delay       (delay),
    .i_line        (line_data),
    .o_accept      (i_access_accept_reply),
    .o_reject      (i_access_reject_reply),
    .o_sec_holds   (i_sec_holds_line),
    .o_store_valid (i_store_operand_valid),
    .o_sec_valid   (i_sec_operand_valid),
    .o_store_data  (i_store_operand),
    .o_sec_data    (i_sec_operand)
  );

  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  // Pulse counters; non-blocking so snapshots at an edge are never racy
  always @(posedge i_clock) begin
    for (int k = 0; k < 15; k++) cnt[k] <= cnt[k] + ev[k];
    if (o_writeback_valid) wb_data <= o_writeback_data;
    if (o_writeback_valid) wb_vaddr <= o_writeback_vaddr;
  end

  function automatic int d(input int k);
    return cnt[k] - base[k];
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One stage-4 access, then the reference line array is updated and compared
  task automatic access(input logic [31:0] m, input logic aw, input logic stv, input logic [1:0] md,
                        input string nm);
    int k, v, f;
    @(posedge i_clock);
    base = cnt;
    v = (i_acc_store_pending && i_acc_store_home == 5'(ptr)) ? (ptr + 1) % 23 : ptr;
    line_data          <= {$random(seed), $random(seed)};
    i_found_operand    <= {$random(seed), $random(seed)};
    i_vaddr            <= 20'($random(seed));
    i_rsv_addr         <= 3'($random(seed));
    i_overlap_store_s4 <= 1'($random(seed));
    delay              <= 2'($random(seed));
    i_xlate_miss       <= i_console_bypass_signal | 1'($random(seed));
    {i_line_match, i_acc_write, i_store_to_var, mode, i_access_valid} <= {m, aw, stv, md, 1'b1};
    @(posedge i_clock);
    i_access_valid <= 1'b0;
    for (k = 0; k < 80; k++) begin
      @(posedge i_clock);
      if (o_stage4_stall === 1'b0) break;
    end
    if (k == 80) begin
      bad_count++;
      conclude();
    end
    repeat (3) @(posedge i_clock);
    i_line_match <= 32'h0;
    if ($countones(m) > 1)
      chk(d(6) > 0, 1);
    else if (i_console_bypass_signal) begin
      chk(d(5) > 0, 1);
      chk(d(0), 0);
      chk(d(1) > 0, 1);
    end else if (m != 32'h0) begin
      k = $clog2(m);
      chk(d(3), exp_alt[k]);
      chk(d(11), 1);
      if (exp_alt[k]) chk(wb_data, i_found_operand);
      if (exp_alt[k]) chk(wb_vaddr, i_vaddr);
      exp_used[k] = 1'b0;
      exp_alt[k] = 1'b0;
    end else begin
      chk(d(0), 1);
      chk(d(1) > 0 && d(10) > 0, 1);
      chk(d(4), exp_alt[v]);
      chk(d(14), exp_alt[v] & i_xlate_miss);
      if (exp_alt[v]) chk(wb_data, lines[v]);
      exp_alt[v] = 1'b0;
      chk(d(2), md == 2'h1);
      f = (md == 2'h0 || (md == 2'h2 && stv));
      chk(d(11), f);
      chk(d(12), f);
      chk(d(13), f & i_overlap_store_s4);
      if (f) begin
        exp_used[v] = 1'b1;
        exp_alt[v] = (md == 2'h2);
        lines[v] = line_data;
        ptr = (v + 1) % 23;
        chk(o_fill_line, v);
      end
    end
    chk(o_used, exp_used);
    chk(o_altered, exp_alt);
    $display("test %s done", nm);
  endtask

  // Main sequence; level-0 stays low, pipe discard and store home operand arrival pulse only at the end
  initial begin
    seed = 32'h5275c9c7;
    {i_rst_b, i_access_valid, i_acc_write, i_store_to_var, i_level0, i_acc_store_pending} = 6'h00;
    {i_overlap_store_s4, i_console_bypass_signal, i_xlate_miss, i_acc_store_operand_valid} = 4'h0;
    {i_fetch_xlate_int, i_fetch_ovf_int, i_pipe_discard, i_interrupt_entry} = 4'h0;
    {i_line_match, i_rsv_addr, i_vaddr, i_acc_store_home, mode, delay} = '0;
    {i_found_operand, line_data} = '0;
    exp_used = 32'h0f000000;
    exp_alt = 32'h0;
    repeat (2) @(posedge i_clock);
    i_rst_b <= 1'b1;
    @(posedge i_clock);
    chk(o_used, exp_used);
    chk(o_altered, 32'h0);
    access(32'h0, 1'b0, 1'b1, 2'h2, "held store-to-variable miss");
    access(32'h1, 1'b1, 1'b0, 2'h0, "write equivalence");
    access(32'h0, 1'b0, 1'b0, 2'h2, "held line without insert");
    access(32'h0, 1'b0, 1'b0, 2'h1, "rejected miss");
    for (int i = 0; i < 30; i++) begin
      i_acc_store_pending <= (i == 5);
      i_acc_store_home <= 5'(ptr);
      access(32'h0, 1'b0, 1'($random(seed)), 2'($unsigned($random(seed)) % 3), "random miss");
    end
    access(32'h1 << ((ptr + 22) % 23), 1'b1, 1'b0, 2'h0, "write equivalence on newest line");
    access(32'h6, 1'b0, 1'b0, 2'h0, "multiple match");
    {i_console_bypass_signal, i_xlate_miss} <= 2'h3;
    access(32'h0, 1'b0, 1'b0, 2'h0, "console bypass");
    {i_console_bypass_signal, i_xlate_miss} <= 2'h0;
    // Write hit on the outstanding store home line must not start
    {i_acc_store_pending, i_acc_store_home, i_line_match} <= {1'b1, 5'h03, 32'h8};
    {i_acc_write, i_access_valid} <= 2'h3;
    @(posedge i_clock);
    i_access_valid <= 1'b0;
    @(posedge i_clock);
    chk(o_stage4_stall, 0);
    chk(o_used, exp_used);
    {i_acc_store_pending, i_line_match, i_acc_write} <= '0;
    base = cnt;
    i_fetch_xlate_int <= 1'b1;
    @(posedge i_clock);
    i_fetch_xlate_int <= 1'b0;
    repeat (6) @(posedge i_clock);
    chk(o_fetch_priority_flag, 1);
    chk(d(7) > 0 && d(8) > 0, 1);
    i_interrupt_entry <= 1'b1;
    @(posedge i_clock);
    {i_interrupt_entry, i_fetch_ovf_int} <= 2'h1;
    @(posedge i_clock);
    i_fetch_ovf_int <= 1'b0;
    repeat (4) @(posedge i_clock);
    chk(o_fetch_priority_flag, 0);
    chk(d(9) > 0, 1);
    // Fetch interrupt discarded with the pipe leaves the flag alone
    {i_fetch_xlate_int, i_pipe_discard} <= 2'h3;
    @(posedge i_clock);
    {i_fetch_xlate_int, i_pipe_discard} <= 2'h0;
    i_acc_store_operand_valid <= 1'b1;
    @(posedge i_clock);
    chk(o_fetch_priority_flag, 0);
    chk(o_store_home_write, 1);
    i_acc_store_operand_valid <= 1'b0;
    $display("test fetch interrupts done");
    conclude();
  end
endmodule

// >>> sim/onsmc_far_model.sv
// Far-side model: secondary operand buffer plus store access controller
`timescale 1ns/100ps
module onsmc_far_model (
  input  wire logic        i_clock,
  input  wire logic        i_order,
  input  wire logic [1:0]  i_mode,
  input  wire logic [1:0]  i_delay,
  input  wire logic [63:0] i_line,
  output logic             o_accept,
  output logic             o_reject,
  output logic             o_sec_holds,
  output logic             o_store_valid,
  output logic             o_sec_valid,
  output logic [63:0]      o_store_data,
  output logic [63:0]      o_sec_data
);
  // One miss-fetch order at a time; mode 0 store read, 1 reject, 2 line held here
  initial begin
    {o_accept, o_reject, o_sec_holds, o_store_valid, o_sec_valid} = 5'h00;
    o_store_data = 64'h0;
    o_sec_data   = 64'h0;
    forever begin
      @(posedge i_clock);
      if (i_order) begin
        repeat (i_delay) @(posedge i_clock);
        o_accept    <= (i_mode != 2'h1);
        o_reject    <= (i_mode == 2'h1);
        o_sec_holds <= (i_mode == 2'h2);
        @(posedge i_clock);
        {o_accept, o_reject, o_sec_holds} <= 3'h0;
        if (i_mode != 2'h1) begin
          // Held line and store read both wait the same delay before landing
          repeat (i_delay) @(posedge i_clock);
          o_store_valid <= (i_mode == 2'h0);
          o_sec_valid   <= (i_mode == 2'h2);
          o_store_data  <= i_line;
          o_sec_data    <= i_line;
          @(posedge i_clock);
          {o_store_valid, o_sec_valid} <= 2'h0;
          // Released lines must not keep the old value
          o_store_data <= ~i_line;
          o_sec_data   <= ~i_line;
        end
      end
    end
  end
endmodule
